//--- rtl/jtp_pkg.sv
// Contract
// - TAP state advances on every rising test clock.
// - Data input sampled rising edge, routed by state.
// - Data output changes on falling test clock edge.
// - Five mode-select-high clocks reach Test-Logic-Reset.
// - Test-Logic-Reset restores instruction and data defaults.
// - Power-on reset forces Test-Logic-Reset without test clock.
// - Stopped test clock keeps state and chain contents.
// - Data output not driven outside shift states.
// - Unimplemented instruction codes decode as bypass.
// - External and internal test never capture, shift, update.
// - Latched instruction selects the data chain used.
// - TAP state chooses instruction or data chain.
// - Chains capture, shift toward output, then update.
// - Pins reset into debug function; commit guards reassign.
// - Instruction chain is four bits wide.
// - Instruction picks own or core TAP data output.
package jtp_pkg;

	localparam int IR_W = 4;

	localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
	localparam logic [IR_W-1:0] IR_INTEST  = 4'h1;
	localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h2;
	localparam logic [IR_W-1:0] IR_ABORT   = 4'h8;
	localparam logic [IR_W-1:0] IR_DPACC   = 4'ha;
	localparam logic [IR_W-1:0] IR_APACC   = 4'hb;
	localparam logic [IR_W-1:0] IR_IDCODE  = 4'he;
	localparam logic [IR_W-1:0] IR_BYPASS  = 4'hf;

	// Fixed pattern loaded into the instruction chain on capture.
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_W-1:0] IR_RESET   = IR_IDCODE;

	// Identification value is arbitrary; bit 0 must stay set.
	localparam logic [31:0] IDCODE_VALUE   = 32'h0000_0001;
	localparam int          BSR_W_DEFAULT  = 8;
	localparam logic [3:0]  PULLUP_RESET   = 4'hf;
	localparam logic        DEBUG_FN_RESET = 1'b1;

	typedef enum logic [3:0] {
		ST_TLR, ST_RTI,
		ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR,
		ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR,
		ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} jtp_tap_state_t;

	typedef struct packed {
		logic tlr;
		logic cap_dr;
		logic shf_dr;
		logic upd_dr;
		logic cap_ir;
		logic shf_ir;
		logic upd_ir;
	} jtp_tap_ctl_t;

	typedef struct packed {
		logic [3:0] pullup_en;
		logic       debug_func;
	} jtp_pin_cfg_t;

	function automatic logic jtp_is_core(input logic [IR_W-1:0] ir);
		return (ir == IR_ABORT) || (ir == IR_DPACC) || (ir == IR_APACC);
	endfunction : jtp_is_core

	function automatic logic jtp_is_impl(input logic [IR_W-1:0] ir);
		return jtp_is_core(ir) || (ir == IR_EXTEST) || (ir == IR_INTEST)
			|| (ir == IR_SAMPLE) || (ir == IR_IDCODE)
			|| (ir == IR_BYPASS);
	endfunction : jtp_is_impl

endpackage : jtp_pkg

//--- rtl/jtp_tap_fsm.sv
`timescale 1ns/1ps
module jtp_tap_fsm
	import jtp_pkg::*;
(
	input  wire logic           tck,
	input  wire logic           por,
	input  wire logic           tms,
	output jtp_tap_state_t      state_q,
	output jtp_tap_ctl_t        ctl
);

	jtp_tap_state_t state_d;

	always_comb begin
		state_d = ST_TLR;
		case (state_q)
			ST_TLR:    state_d = tms ? ST_TLR    : ST_RTI;
			ST_RTI:    state_d = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_d = tms ? ST_EX1_DR : ST_SHF_DR;
			ST_SHF_DR: state_d = tms ? ST_EX1_DR : ST_SHF_DR;
			ST_EX1_DR: state_d = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: state_d = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: state_d = tms ? ST_UPD_DR : ST_SHF_DR;
			ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: state_d = tms ? ST_TLR    : ST_CAP_IR;
			ST_CAP_IR: state_d = tms ? ST_EX1_IR : ST_SHF_IR;
			ST_SHF_IR: state_d = tms ? ST_EX1_IR : ST_SHF_IR;
			ST_EX1_IR: state_d = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: state_d = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: state_d = tms ? ST_UPD_IR : ST_SHF_IR;
			ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_RTI;
			default:   state_d = ST_TLR;
		endcase
	end

	// Clocked only by the test clock, so a stopped clock freezes the state.
	always_ff @(posedge tck or posedge por) begin
		if (por) begin
			state_q <= ST_TLR;
		end else begin
			state_q <= state_d;
		end
	end

	always_comb begin
		ctl        = '0;
		ctl.tlr    = (state_q == ST_TLR);
		ctl.cap_dr = (state_q == ST_CAP_DR);
		ctl.shf_dr = (state_q == ST_SHF_DR);
		ctl.upd_dr = (state_q == ST_UPD_DR);
		ctl.cap_ir = (state_q == ST_CAP_IR);
		ctl.shf_ir = (state_q == ST_SHF_IR);
		ctl.upd_ir = (state_q == ST_UPD_IR);
	end

	default clocking cb @(posedge tck); endclocking
	default disable iff (por);

	chk_five_ones_tlr: assert property (
		tms [*5] |=> state_q == ST_TLR)
		else $error("Five high mode-select clocks did not reach reset.");

	chk_shift_dr_hold: assert property (
		state_q == ST_SHF_DR && !tms |=> state_q == ST_SHF_DR)
		else $error("Shift-DR left with mode select low.");

	chk_sel_ir_walk: assert property (
		state_q == ST_SEL_DR && tms ##1 tms |=> state_q == ST_TLR)
		else $error("Select-DR, Select-IR with high did not reach reset.");

	chk_update_idle: assert property (
		(state_q == ST_UPD_DR || state_q == ST_UPD_IR) && !tms
		|=> state_q == ST_RTI)
		else $error("Update with mode select low did not go idle.");

	cov_ir_scan: cover property (
		state_q == ST_CAP_IR ##1 state_q == ST_SHF_IR [*4]
		##[1:8] state_q == ST_UPD_IR);

	cov_dr_pause: cover property (
		state_q == ST_PAU_DR ##[1:8] state_q == ST_SHF_DR);

endmodule : jtp_tap_fsm

//--- rtl/jtp_port.sv
`timescale 1ns/1ps
module jtp_port
	import jtp_pkg::*;
#(
	parameter int BSR_W = BSR_W_DEFAULT
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             tck,
	input  wire logic             tms,
	input  wire logic             tdi,
	input  wire logic             core_tdo,
	input  wire logic [BSR_W-1:0] bscan_pin_in,
	input  wire logic             alt_func_wr,
	input  wire logic             alt_func_val,
	input  wire logic             pullup_wr,
	input  wire logic [3:0]       pullup_val,
	input  wire logic             commit_unlocked,
	output logic                  tdo_q,
	output logic                  tdo_oe_q,
	output logic                  core_sel_q,
	output logic                  bscan_drive_q,
	output logic [BSR_W-1:0]      bscan_pin_out_q,
	output jtp_pin_cfg_t          pin_cfg_q,
	output logic                  tlr_sys_q,
	output logic [IR_W-1:0]       instr_sys_q
);

	// System-clock side: reset register, pin configuration.

	logic por_q;

	// The registered reset is the asynchronous reset of the test-clock
	// logic, so the TAP returns to reset even with the test clock stopped.
	always_ff @(posedge clk_sys) begin
		por_q <= rst;
	end

	// Writes that would drop the mode-select or data-input pull-ups are
	// accepted; keeping them enabled is left to software.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_cfg_q.debug_func <= DEBUG_FN_RESET;
			pin_cfg_q.pullup_en  <= PULLUP_RESET;
		end else if (commit_unlocked) begin
			if (alt_func_wr) begin
				pin_cfg_q.debug_func <= alt_func_val;
			end
			if (pullup_wr) begin
				pin_cfg_q.pullup_en <= pullup_val;
			end
		end
	end

	// TAP state machine.

	jtp_tap_state_t state_q;
	jtp_tap_ctl_t   ctl;

	jtp_tap_fsm u_fsm (
		.tck     (tck),
		.por     (por_q),
		.tms     (tms),
		.state_q (state_q),
		.ctl     (ctl)
	);

	// Boundary pins come from outside the test-clock domain.

	logic [BSR_W-1:0] pin_meta_q;
	logic [BSR_W-1:0] pin_sync_q;

	always_ff @(posedge tck or posedge por_q) begin
		if (por_q) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= bscan_pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// Instruction chain.

	logic [IR_W-1:0] ir_shift_q;
	logic [IR_W-1:0] ir_q;

	always_ff @(posedge tck or posedge por_q) begin
		if (por_q) begin
			ir_shift_q <= IR_CAPTURE;
		end else if (ctl.tlr) begin
			ir_shift_q <= IR_CAPTURE;
		end else if (ctl.cap_ir) begin
			ir_shift_q <= IR_CAPTURE;
		end else if (ctl.shf_ir) begin
			ir_shift_q <= {tdi, ir_shift_q[IR_W-1:1]};
		end
	end

	always_ff @(posedge tck or posedge por_q) begin
		if (por_q) begin
			ir_q <= IR_RESET;
		end else if (ctl.tlr) begin
			ir_q <= IR_RESET;
		end else if (ctl.upd_ir) begin
			ir_q <= ir_shift_q;
		end
	end

	// Chain selection from the latched instruction.

	logic [IR_W-1:0] ir_eff;
	logic            sel_id;
	logic            sel_bsr;
	logic            sel_core;
	logic            sel_test;

	always_comb begin
		ir_eff   = jtp_is_impl(ir_q) ? ir_q : IR_BYPASS;
		sel_id   = (ir_eff == IR_IDCODE);
		sel_bsr  = (ir_eff == IR_SAMPLE);
		sel_core = jtp_is_core(ir_eff);
		sel_test = (ir_eff == IR_EXTEST) || (ir_eff == IR_INTEST);
	end

	// Data chains.

	logic             bypass_q;
	logic [31:0]      id_shift_q;
	logic [BSR_W-1:0] bsr_shift_q;

	// External and internal test fall onto the bypass bit for the serial
	// path, so the boundary chain stays untouched while they are active.
	always_ff @(posedge tck or posedge por_q) begin
		if (por_q) begin
			bypass_q <= 1'b0;
		end else if (ctl.tlr) begin
			bypass_q <= 1'b0;
		end else if (ctl.cap_dr) begin
			bypass_q <= 1'b0;
		end else if (ctl.shf_dr) begin
			bypass_q <= tdi;
		end
	end

	always_ff @(posedge tck or posedge por_q) begin
		if (por_q) begin
			id_shift_q <= IDCODE_VALUE;
		end else if (ctl.tlr) begin
			id_shift_q <= IDCODE_VALUE;
		end else if (ctl.cap_dr && sel_id) begin
			id_shift_q <= IDCODE_VALUE;
		end else if (ctl.shf_dr && sel_id) begin
			id_shift_q <= {tdi, id_shift_q[31:1]};
		end
	end

	always_ff @(posedge tck or posedge por_q) begin
		if (por_q) begin
			bsr_shift_q <= '0;
		end else if (ctl.tlr) begin
			bsr_shift_q <= '0;
		end else if (ctl.cap_dr && sel_bsr) begin
			bsr_shift_q <= pin_sync_q;
		end else if (ctl.shf_dr && sel_bsr) begin
			bsr_shift_q <= {tdi, bsr_shift_q[BSR_W-1:1]};
		end
	end

	always_ff @(posedge tck or posedge por_q) begin
		if (por_q) begin
			bscan_pin_out_q <= '0;
		end else if (ctl.tlr) begin
			bscan_pin_out_q <= '0;
		end else if (ctl.upd_dr && sel_bsr) begin
			bscan_pin_out_q <= bsr_shift_q;
		end
	end

	// Test instructions act on the data already held in the update stage.
	always_ff @(posedge tck or posedge por_q) begin
		if (por_q) begin
			bscan_drive_q <= 1'b0;
			core_sel_q    <= 1'b0;
		end else begin
			bscan_drive_q <= sel_test && !ctl.tlr;
			core_sel_q    <= sel_core && !ctl.tlr;
		end
	end

	// Serial output on the falling test-clock edge.

	logic dr_bit;

	always_comb begin
		if (sel_core) begin
			dr_bit = core_tdo;
		end else if (sel_id) begin
			dr_bit = id_shift_q[0];
		end else if (sel_bsr) begin
			dr_bit = bsr_shift_q[0];
		end else begin
			dr_bit = bypass_q;
		end
	end

	always_ff @(negedge tck or posedge por_q) begin
		if (por_q) begin
			tdo_q    <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_q    <= ctl.shf_ir ? ir_shift_q[0] : dr_bit;
			tdo_oe_q <= ctl.shf_ir || ctl.shf_dr;
		end
	end

	// Crossing to the system clock.

	logic ir_tgl_q;

	// The instruction cannot change again within two test clocks, which
	// leaves ample time for the system side to take the stable word.
	always_ff @(posedge tck or posedge por_q) begin
		if (por_q) begin
			ir_tgl_q <= 1'b0;
		end else if ((ctl.tlr && ir_q != IR_RESET) || ctl.upd_ir) begin
			ir_tgl_q <= !ir_tgl_q;
		end
	end

	// A decoded state can glitch, so the reset flag is registered before
	// it crosses to the system clock.
	logic tlr_tck_q;

	always_ff @(negedge tck or posedge por_q) begin
		if (por_q) begin
			tlr_tck_q <= 1'b1;
		end else begin
			tlr_tck_q <= ctl.tlr;
		end
	end

	logic tgl_meta_q;
	logic tgl_sync_q;
	logic tgl_seen_q;
	logic tlr_meta_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tgl_meta_q <= 1'b0;
			tgl_sync_q <= 1'b0;
			tgl_seen_q <= 1'b0;
		end else begin
			tgl_meta_q <= ir_tgl_q;
			tgl_sync_q <= tgl_meta_q;
			tgl_seen_q <= tgl_sync_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			instr_sys_q <= IR_RESET;
		end else if (tgl_sync_q != tgl_seen_q) begin
			instr_sys_q <= ir_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tlr_meta_q <= 1'b1;
			tlr_sys_q  <= 1'b1;
		end else begin
			tlr_meta_q <= tlr_tck_q;
			tlr_sys_q  <= tlr_meta_q;
		end
	end

	// Checks in the test-clock domain.

	chk_tdo_oe_shift: assert property (
		@(posedge tck) disable iff (por_q)
		tdo_oe_q == (state_q == ST_SHF_DR || state_q == ST_SHF_IR))
		else $error("Data output enable does not match shift state.");

	chk_tdo_ir_bit: assert property (
		@(posedge tck) disable iff (por_q)
		state_q == ST_SHF_IR ##1 state_q == ST_SHF_IR
		|-> tdo_q == ir_shift_q[0])
		else $error("Data output did not follow instruction chain.");

	chk_ir_update: assert property (
		@(posedge tck) disable iff (por_q)
		ctl.upd_ir |=> ir_q == $past(ir_shift_q))
		else $error("Instruction not latched on update.");

	chk_ir_tlr_default: assert property (
		@(posedge tck) disable iff (por_q)
		ctl.tlr |=> ir_q == IR_RESET && bscan_pin_out_q == '0)
		else $error("Reset state did not restore defaults.");

	chk_ir_capture: assert property (
		@(posedge tck) disable iff (por_q)
		ctl.cap_ir |=> ir_shift_q == IR_CAPTURE)
		else $error("Instruction capture pattern wrong.");

	chk_bypass_unknown: assert property (
		@(posedge tck) disable iff (por_q)
		ctl.shf_dr && !jtp_is_impl(ir_q) |=> bypass_q == $past(tdi))
		else $error("Unimplemented code did not act as bypass.");

	chk_test_no_shift: assert property (
		@(posedge tck) disable iff (por_q)
		(ir_q == IR_EXTEST || ir_q == IR_INTEST) && !ctl.tlr
		|=> $stable(bsr_shift_q) && $stable(bscan_pin_out_q))
		else $error("Test instruction touched the boundary chain.");

	chk_test_drive: assert property (
		@(posedge tck) disable iff (por_q)
		sel_test && !ctl.tlr |=> bscan_drive_q)
		else $error("Test instruction did not apply held pin data.");

	chk_core_select: assert property (
		@(posedge tck) disable iff (por_q)
		state_q == ST_SHF_DR && jtp_is_core(ir_q) ##1 1'b1
		|-> core_sel_q)
		else $error("Core instruction did not select core output.");

	// Checks in the system-clock domain.

	chk_pin_cfg_lock: assert property (
		@(posedge clk_sys) disable iff (rst)
		!commit_unlocked |=> $stable(pin_cfg_q))
		else $error("Pin configuration changed while locked.");

	chk_instr_cross: assert property (
		@(posedge clk_sys) disable iff (rst)
		$changed(instr_sys_q) |-> $past(tgl_sync_q != tgl_seen_q))
		else $error("Instruction copy changed without handshake.");

	cov_bsr_update: cover property (
		@(posedge tck) disable iff (por_q)
		ctl.upd_dr && sel_bsr);

	cov_core_shift: cover property (
		@(posedge tck) disable iff (por_q)
		ctl.shf_dr && sel_core);

	cov_sys_instr: cover property (
		@(posedge clk_sys) disable iff (rst)
		$changed(instr_sys_q));

endmodule : jtp_port

//--- testbench/jtp_dbg_model.sv
`timescale 1ns/1ps
module jtp_dbg_model (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe
);

	// The test clock stands still low between frames.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One test clock period; an undriven data output reads high (pull-up).
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#15 tck = 1'b1;
		o = tdo_oe ? tdo : 1'b1;
		#15 tck = 1'b0;
	endtask : step

	task automatic tap_reset();
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask : tap_reset

	// From idle through capture, shift and update back to idle.
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b1, o);
		if (ir) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		// One idle clock lets flags that follow the new instruction settle.
		step(1'b0, 1'b1, o);
	endtask : scan

endmodule : jtp_dbg_model

//--- testbench/jtag_tap_port_tb.sv
`timescale 1ns/1ps
module jtag_tap_port_tb;
	import jtp_pkg::*;

	localparam int BSR_W = 8;

	logic             clk_sys, rst, tck, tms, tdi, core_tdo;
	logic             alt_func_wr, alt_func_val, pullup_wr, commit_unlocked;
	logic [3:0]       pullup_val;
	logic [BSR_W-1:0] bscan_pin_in, bscan_pin_out_q;
	logic             tdo_q, tdo_oe_q, core_sel_q, bscan_drive_q, tlr_sys_q;
	logic [IR_W-1:0]  instr_sys_q;
	jtp_pin_cfg_t     pin_cfg_q;
	logic [31:0]      d;
	int               fails, tests_run, cycles;

	jtp_port #(.BSR_W(BSR_W)) jtp_port_i (
		.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
		.core_tdo(core_tdo), .bscan_pin_in(bscan_pin_in),
		.alt_func_wr(alt_func_wr), .alt_func_val(alt_func_val),
		.pullup_wr(pullup_wr), .pullup_val(pullup_val),
		.commit_unlocked(commit_unlocked), .tdo_q(tdo_q),
		.tdo_oe_q(tdo_oe_q), .core_sel_q(core_sel_q),
		.bscan_drive_q(bscan_drive_q), .bscan_pin_out_q(bscan_pin_out_q),
		.pin_cfg_q(pin_cfg_q), .tlr_sys_q(tlr_sys_q),
		.instr_sys_q(instr_sys_q)
	);

	jtp_dbg_model jtp_dbg_model_i (
		.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_q), .tdo_oe(tdo_oe_q)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			results();
		end
	end

	task automatic sys_wait(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : sys_wait

	task automatic load_ir(input logic [3:0] code);
		jtp_dbg_model_i.scan(1'b1, 4, {28'h0, code}, d);
	endtask : load_ir

	task automatic sys_write(input logic pu, input logic [3:0] v,
		input logic af, input logic cu);
		pullup_wr = pu;
		alt_func_wr = !pu;
		pullup_val = v;
		alt_func_val = af;
		commit_unlocked = cu;
		sys_wait(1);
		pullup_wr = 1'b0;
		alt_func_wr = 1'b0;
		sys_wait(1);
	endtask : sys_write

	task automatic t_reset_values();
		check("pin_cfg", pin_cfg_q, {PULLUP_RESET, DEBUG_FN_RESET});
		check("tlr", tlr_sys_q, 1'b1);
		check("instr", instr_sys_q, IR_RESET);
		check("oe", tdo_oe_q, 1'b0);
		check("drive", bscan_drive_q, 1'b0);
	endtask : t_reset_values

	task automatic t_ir_path();
		load_ir(IR_SAMPLE);
		check("ir_cap", d[3:0], IR_CAPTURE);
		sys_wait(60);
		check("instr", instr_sys_q, IR_SAMPLE);
		check("tlr", tlr_sys_q, 1'b0);
		check("oe", tdo_oe_q, 1'b0);
	endtask : t_ir_path

	task automatic t_boundary();
		bscan_pin_in = 8'ha5;
		jtp_dbg_model_i.scan(1'b0, BSR_W, 32'h3c, d);
		check("bsr_cap", d[7:0], 8'ha5);
		load_ir(IR_EXTEST);
		sys_wait(8);
		check("drive", bscan_drive_q, 1'b1);
		check("pins", bscan_pin_out_q, 8'h3c);
		jtp_dbg_model_i.scan(1'b0, 2, 32'h1, d);
		check("ext_path", d[1:0], 2'b10);
		check("pins", bscan_pin_out_q, 8'h3c);
	endtask : t_boundary

	task automatic t_bypass();
		logic [3:0] codes [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9,
			4'hc, 4'hd, IR_BYPASS};
		foreach (codes[i]) begin
			load_ir(codes[i]);
			jtp_dbg_model_i.scan(1'b0, 3, 32'h5, d);
			check("bypass", d[2:0], 3'b010);
			check("core_sel", core_sel_q, 1'b0);
		end
	endtask : t_bypass

	task automatic t_core();
		logic [3:0] codes [3] = '{IR_ABORT, IR_DPACC, IR_APACC};
		foreach (codes[i]) begin
			core_tdo = codes[i][0];
			load_ir(codes[i]);
			check("core_sel", core_sel_q, 1'b1);
			jtp_dbg_model_i.scan(1'b0, 4, 32'h0, d);
			check("core_tdo", d[3:0], {4{codes[i][0]}});
		end
	endtask : t_core

	task automatic t_tap_reset();
		load_ir(IR_BYPASS);
		jtp_dbg_model_i.tap_reset();
		jtp_dbg_model_i.scan(1'b0, 32, 32'h0, d);
		check("idcode", d, IDCODE_VALUE);
		sys_wait(8);
		check("instr", instr_sys_q, IR_IDCODE);
	endtask : t_tap_reset

	// Tms and tdi pull-ups stay on, or the debugger would lose the port.
	task automatic t_pin_cfg();
		sys_write(1'b1, 4'h0, 1'b0, 1'b0);
		check("locked", pin_cfg_q, {PULLUP_RESET, DEBUG_FN_RESET});
		sys_write(1'b1, 4'h6, 1'b0, 1'b1);
		sys_write(1'b0, 4'h0, 1'b0, 1'b1);
		check("unlocked", pin_cfg_q, {4'h6, 1'b0});
	endtask : t_pin_cfg

	task automatic t_por();
		load_ir(IR_SAMPLE);
		sys_wait(1);
		rst = 1'b1;
		sys_wait(3);
		rst = 1'b0;
		sys_wait(8);
		t_reset_values();
	endtask : t_por

	initial begin
		rst = 1'b1;
		core_tdo = 1'b0;
		bscan_pin_in = '0;
		alt_func_wr = 1'b0;
		alt_func_val = 1'b1;
		pullup_wr = 1'b0;
		pullup_val = 4'hf;
		commit_unlocked = 1'b0;
		fails = 0;
		tests_run = 0;
		cycles = 0;
		sys_wait(3);
		rst = 1'b0;
		sys_wait(8);
		t_reset_values();
		jtp_dbg_model_i.tap_reset();
		t_ir_path();
		t_boundary();
		t_bypass();
		t_core();
		t_tap_reset();
		t_pin_cfg();
		t_por();
		results();
	end

endmodule : jtag_tap_port_tb
